// ### msq_alu.sv
// Purpose: Shared constants for the microstep sequencer and its ALU
//          function selector (ALU, B-leg mux, shift-in steering).
// Assumes: Single processor clock; the ALU module is purely combinational.
// Notes:   The top module registers the ALU result and shift-in outputs; b_leg is not registered.
`timescale 1ns/1ps

package msq_pkg;
  // ----------------------------------------------------------------------
  // Widths and control word layout
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NXT_W = 8;
  localparam int unsigned CS_W = 48;
  localparam int unsigned NXT_LSB = 0;
  localparam int unsigned TEST_LSB = 8;
  localparam int unsigned BLEG_LSB = 11;
  localparam int unsigned CIN_BIT = 13;
  localparam int unsigned ALU_LSB = 33;
  localparam int unsigned ALU_MSB = 37;
  localparam logic [7:0] START_ADDR = 8'h00;

  // ----------------------------------------------------------------------
  // ALU function codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] PASS_A_PLAIN = 5'h00;
  localparam logic [4:0] PASS_A_ARITH = 5'h01;
  localparam logic [4:0] A_AND_B = 5'h02;
  localparam logic [4:0] A_AND_NOT_B = 5'h03;
  localparam logic [4:0] ZERO = 5'h04;
  localparam logic [4:0] PASS_B_PLAIN = 5'h05;
  localparam logic [4:0] A_PLUS_B = 5'h06;
  localparam logic [4:0] A_EXCLUSIVE_OR_B = 5'h07;
  localparam logic [4:0] A_MINUS_B_MINUS_1 = 5'h08;
  localparam logic [4:0] A_OR_B = 5'h09;
  localparam logic [4:0] INVERT_B = 5'h0a;
  localparam logic [4:0] ALL_ONES = 5'h0b;
  localparam logic [4:0] A_MINUS_1 = 5'h0c;
  localparam logic [4:0] INVERT_A = 5'h0d;
  localparam logic [4:0] ARITH_SHIFT_LEFT = 5'h10;
  localparam logic [4:0] ROTATE_LEFT = 5'h11;
  localparam logic [4:0] ARITH_SHIFT_RIGHT = 5'h12;
  localparam logic [4:0] ROTATE_RIGHT = 5'h13;

  // B-leg sources
  localparam logic [1:0] BLEG_B = 2'h0;
  localparam logic [1:0] SIGN_EXTEND_B = 2'h1;
  localparam logic [1:0] BLEG_ONE = 2'h2;

  // ----------------------------------------------------------------------
  // Branch tests and the codes they OR into the next step
  // ----------------------------------------------------------------------
  localparam logic [2:0] TEST_NONE = 3'h0;
  localparam logic [2:0] TEST_OPCODE = 3'h1;
  localparam logic [2:0] TEST_DEST = 3'h2;
  localparam logic [2:0] TEST_DEST_CC = 3'h3;
  localparam logic [2:0] TEST_BYTE = 3'h4;
  localparam logic [2:0] TEST_MOVE = 3'h5;
  localparam logic [2:0] TEST_NONMOD = 3'h6;
  localparam logic [2:0] TEST_SERVICE = 3'h7;

  localparam logic [4:0] DSP_SRC = 5'h00;
  localparam logic [4:0] DSP_DST = 5'h08;
  localparam logic [4:0] DSP_BR_TAKEN = 5'h10;
  localparam logic [4:0] DSP_BR_NOT = 5'h11;
  localparam logic [4:0] DSP_CC = 5'h12;
  localparam logic [4:0] DSP_SUB_RET = 5'h13;
  localparam logic [4:0] DSP_INT_RET = 5'h14;
  localparam logic [4:0] DSP_WAIT = 5'h15;
  localparam logic [4:0] DSP_HALT = 5'h16;
  localparam logic [4:0] DSP_EMUL = 5'h17;
  localparam logic [4:0] DSP_BPT = 5'h18;
  localparam logic [4:0] DSP_IOT = 5'h19;
  localparam logic [4:0] DSP_TRAP = 5'h1a;
  localparam logic [4:0] DSP_RSVD = 5'h1b;
  localparam logic [4:0] DSP_BUS_RESET = 5'h1c;

  localparam logic [1:0] MOVE_BYTE_OTHER = 2'h1;
  localparam logic [1:0] MOVE_BYTE = 2'h2;
  localparam logic [1:0] MOVE_WORD = 2'h3;

  localparam logic [3:0] SRV_FETCH = 4'h0;
  localparam logic [3:0] SRV_TRACE = 4'h1;
  localparam logic [3:0] SRV_STACK = 4'h2;
  localparam logic [3:0] SRV_PWRF = 4'h3;
  localparam logic [3:0] SRV_BUS_GRANT = 4'h4;
  localparam logic [3:0] SRV_LINE_CLK = 4'h5;
  localparam logic [3:0] SRV_SER_RX = 4'h6;
  localparam logic [3:0] SRV_SER_TX = 4'h7;
  localparam logic [3:0] SRV_WAIT = 4'h8;
endpackage : msq_pkg

// ------------------------------------------------------------------------
// Combinational ALU with B-leg selector
// ------------------------------------------------------------------------
module msq_alu #(
  parameter int unsigned W = 16
) (
  input wire logic [4:0] fn,
  input wire logic [1:0] bleg_sel,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b_reg,
  input wire logic carry_in,
  output logic [W-1:0] b_leg,
  output logic [W-1:0] result,
  output logic shift_in_lsb,
  output logic shift_in_msb
);
  always_comb begin
    case (bleg_sel)
      msq_pkg::SIGN_EXTEND_B: b_leg = {{(W-8){b_reg[7]}}, b_reg[7:0]};
      msq_pkg::BLEG_ONE: b_leg = {{(W-1){1'b0}}, 1'b1};
      default: b_leg = b_reg;
    endcase
  end

  always_comb begin
    case (fn)
      msq_pkg::PASS_A_ARITH: result = a + {{(W-1){1'b0}}, carry_in};
      msq_pkg::A_AND_B: result = a & b_leg;
      msq_pkg::A_AND_NOT_B: result = a & ~b_leg;
      msq_pkg::ZERO: result = '0;
      msq_pkg::A_OR_B: result = a | b_leg;
      msq_pkg::PASS_B_PLAIN: result = b_leg;
      msq_pkg::A_PLUS_B: result = a + b_leg + {{(W-1){1'b0}}, carry_in};
      msq_pkg::A_EXCLUSIVE_OR_B: result = a ^ b_leg;
      msq_pkg::A_MINUS_B_MINUS_1:
        result = a + ~b_leg + {{(W-1){1'b0}}, carry_in};
      msq_pkg::INVERT_B: result = ~b_leg;
      msq_pkg::ALL_ONES: result = '1;
      msq_pkg::A_MINUS_1: result = a + {W{1'b1}} + {{(W-1){1'b0}}, carry_in};
      msq_pkg::INVERT_A: result = ~a;
      msq_pkg::ARITH_SHIFT_LEFT, msq_pkg::ROTATE_LEFT,
      msq_pkg::ARITH_SHIFT_RIGHT, msq_pkg::ROTATE_RIGHT: result = b_leg;
      default: result = a;
    endcase
  end

  // serial shift-in steering; rotates recirculate the carry
  always_comb begin
    shift_in_lsb = 1'b0;
    shift_in_msb = 1'b0;
    case (fn)
      msq_pkg::ROTATE_LEFT: shift_in_lsb = carry_in;
      msq_pkg::ARITH_SHIFT_RIGHT: shift_in_msb = b_reg[W-1];
      msq_pkg::ROTATE_RIGHT: shift_in_msb = carry_in;
      default: shift_in_lsb = 1'b0;
    endcase
  end
endmodule : msq_alu

// ### msq_cstore.sv
// Purpose: Control store model on the far side of the sequencer.
// Assumes: Read is combinational from the counter; one write port.
// Notes:   Every word starts as a step that loops on its own address,
//          so the sequencer parks while the bench loads a test word.
`timescale 1ns/1ps

module msq_cstore (
  input wire logic clk,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [47:0] wr_data,
  output logic [47:0] word
);
  logic [47:0] mem [0:256-1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Park program, no branch test anywhere
  // eight-bit next field
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {40'h0, 8'(i)};
    end
  end

  // Loads taken on the rising edge, seen from the next cycle on
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign word = mem[addr];
endmodule : msq_cstore

// ### msq_sequencer.sv
// Purpose: Microstep counter, branch tests and registered ALU outputs.
// Assumes: Control store sits outside and is addressed by the counter;
//          all condition inputs come from logic on the same clock.
// Notes:   Branch codes are ORed into the next step field, so microcode
//          must leave the affected low bits zero at each test site.
`timescale 1ns/1ps

// Overview of operation
// - ALU field picks fourteen data functions
// - Shift codes steer B serial shift-ins
// - ALU field bits 37:33, or is 01001
// - Next step field loads counter each step
// - Counter addresses the control store
// - Conditions ORed into fewest next bits
// - Next step field is eight bits
// - Opcode dispatch routes every instruction class
// - Destination test picks mode or cc
// - Byte test picks even or odd path
// - Move test splits three move cases
// - Test, compare, bit-test skip writeback
// - Service test uses fixed priority order
// - All bus requests share grant entry
// - Idle service fetches, or loops waiting
// - B-leg offers B, sign-extended, one
module msq_sequencer #(
  parameter int unsigned W = msq_pkg::DATA_W,
  parameter int unsigned CSW = msq_pkg::CS_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [CSW-1:0] cs_word,
  input wire logic [15:0] instr,
  input wire logic [3:0] cond_codes,
  input wire logic bus_addr_odd,
  input wire logic [W-1:0] a_bus,
  input wire logic [W-1:0] b_reg,
  input wire logic trace_pend,
  input wire logic stack_ovf,
  input wire logic power_fail,
  input wire logic [3:0] bus_req,
  input wire logic line_clk_pend,
  input wire logic ser_rx_pend,
  input wire logic ser_tx_pend,
  input wire logic wait_active,
  output logic [7:0] microstep_counter,
  output logic [W-1:0] alu_result,
  output logic shift_in_lsb,
  output logic shift_in_msb
);
  // ----------------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------------
  logic [7:0] next_step_field;
  logic [2:0] test_sel;
  logic [1:0] bleg_sel;
  logic [4:0] alu_fn;
  logic carry_in;
  logic [7:0] branch_or;
  logic [7:0] next_counter;
  logic [4:0] dispatch_code;
  logic [3:0] service_code;
  logic [1:0] move_code;
  logic byte_instr;
  logic nonmodify;
  logic [W-1:0] b_leg;
  logic [W-1:0] next_alu_result;
  logic next_shift_lsb;
  logic next_shift_msb;

  assign next_step_field = cs_word[msq_pkg::NXT_LSB +: msq_pkg::NXT_W];
  assign test_sel = cs_word[msq_pkg::TEST_LSB +: 3];
  assign bleg_sel = cs_word[msq_pkg::BLEG_LSB +: 2];
  assign carry_in = cs_word[msq_pkg::CIN_BIT];
  assign alu_fn = cs_word[msq_pkg::ALU_MSB:msq_pkg::ALU_LSB];

  // Branch condition from opcode and flags {n,z,v,c}
  function automatic logic br_taken(input logic [3:0] op,
                                    input logic [3:0] f);
    logic n;
    logic z;
    logic v;
    logic c;
    n = f[3];
    z = f[2];
    v = f[1];
    c = f[0];
    case (op)
      4'h1: br_taken = 1'b1;
      4'h2: br_taken = !z;
      4'h3: br_taken = z;
      4'h4: br_taken = !(n ^ v);
      4'h5: br_taken = n ^ v;
      4'h6: br_taken = !(z | (n ^ v));
      4'h7: br_taken = z | (n ^ v);
      4'h8: br_taken = !n;
      4'h9: br_taken = n;
      4'ha: br_taken = !(c | z);
      4'hb: br_taken = c | z;
      4'hc: br_taken = !v;
      4'hd: br_taken = v;
      4'he: br_taken = !c;
      4'hf: br_taken = c;
      default: br_taken = 1'b0;
    endcase
  endfunction : br_taken

  // ----------------------------------------------------------------------
  // Instruction class decode
  // ----------------------------------------------------------------------
  // opcode dispatch classes
  always_comb begin
    dispatch_code = msq_pkg::DSP_RSVD;
    if (instr[14:12] != 3'h0 && instr[14:12] != 3'h7) begin
      dispatch_code = msq_pkg::DSP_SRC | {2'h0, instr[11:9]};
    end else if (instr[15:8] == 8'h88) begin
      dispatch_code = msq_pkg::DSP_EMUL;
    end else if (instr[15:8] == 8'h89) begin
      dispatch_code = msq_pkg::DSP_TRAP;
    end else if ((instr[15:8] >= 8'h01 && instr[15:8] <= 8'h07) ||
                 (instr[15:8] >= 8'h80 && instr[15:8] <= 8'h87)) begin
      dispatch_code = br_taken({instr[15], instr[10:8]}, cond_codes) ?
                      msq_pkg::DSP_BR_TAKEN : msq_pkg::DSP_BR_NOT;
    end else if (instr[15:9] == 7'h04 || instr[15:6] == 10'h001 ||
                 instr[15:6] == 10'h003 ||
                 (instr[14:6] >= 9'h028 && instr[14:6] <= 9'h037)) begin
      dispatch_code = msq_pkg::DSP_DST | {2'h0, instr[5:3]};
    end else if (instr[15:3] == 13'h0010) begin
      dispatch_code = msq_pkg::DSP_SUB_RET;
    end else if (instr[15:5] == 11'h005) begin
      dispatch_code = msq_pkg::DSP_CC;
    end else begin
      case (instr)
        16'h0000: dispatch_code = msq_pkg::DSP_HALT;
        16'h0001: dispatch_code = msq_pkg::DSP_WAIT;
        16'h0002: dispatch_code = msq_pkg::DSP_INT_RET;
        16'h0003: dispatch_code = msq_pkg::DSP_BPT;
        16'h0004: dispatch_code = msq_pkg::DSP_IOT;
        16'h0005: dispatch_code = msq_pkg::DSP_BUS_RESET;
        default: dispatch_code = msq_pkg::DSP_RSVD;
      endcase
    end
  end

  // move variants; word ops other than move leave bits clear
  // Byte ops: double operand ones (subtract is a word op) and the
  // single operand byte group; all but move byte reach the byte-other path
  always_comb begin
    byte_instr = instr[15] &&
                 ((instr[14:12] != 3'h0 && instr[14:12] < 3'h6) ||
                  (instr[14:6] >= 9'h028 && instr[14:6] <= 9'h037));
    if (instr[15:12] == 4'h9) begin
      move_code = msq_pkg::MOVE_BYTE;
    end else if (instr[15:12] == 4'h1) begin
      move_code = msq_pkg::MOVE_WORD;
    end else if (byte_instr) begin
      move_code = msq_pkg::MOVE_BYTE_OTHER;
    end else begin
      move_code = 2'h0;
    end
  end

  // test, compare and bit-test skip writeback
  assign nonmodify = instr[14:12] == 3'h2 || instr[14:12] == 3'h3 ||
                     instr[14:6] == 9'h02f;

  always_comb begin
    if (trace_pend) begin
      service_code = msq_pkg::SRV_TRACE;
    end else if (stack_ovf) begin
      service_code = msq_pkg::SRV_STACK;
    end else if (power_fail) begin
      service_code = msq_pkg::SRV_PWRF;
    end else if (bus_req[3] || bus_req[2]) begin
      service_code = msq_pkg::SRV_BUS_GRANT;
    end else if (line_clk_pend) begin
      service_code = msq_pkg::SRV_LINE_CLK;
    end else if (bus_req[1] || bus_req[0]) begin
      service_code = msq_pkg::SRV_BUS_GRANT;
    end else if (ser_rx_pend) begin
      service_code = msq_pkg::SRV_SER_RX;
    end else if (ser_tx_pend) begin
      service_code = msq_pkg::SRV_SER_TX;
    end else if (wait_active) begin
      service_code = msq_pkg::SRV_WAIT;
    end else begin
      service_code = msq_pkg::SRV_FETCH;
    end
  end

  // ----------------------------------------------------------------------
  // Next step formation
  // ----------------------------------------------------------------------
  // each test drives only the bits it needs
  always_comb begin
    case (test_sel)
      msq_pkg::TEST_OPCODE: branch_or = {3'h0, dispatch_code};
      msq_pkg::TEST_DEST: branch_or = {5'h00, instr[5:3]};
      msq_pkg::TEST_DEST_CC: branch_or = {7'h00, instr[4]};
      // odd byte only after a non-register (nonzero) source mode
      msq_pkg::TEST_BYTE: branch_or = {6'h00,
        byte_instr && bus_addr_odd && instr[11:9] != 3'h0, byte_instr};
      msq_pkg::TEST_MOVE: branch_or = {6'h00, move_code};
      msq_pkg::TEST_NONMOD: branch_or = {7'h00, nonmodify};
      msq_pkg::TEST_SERVICE: branch_or = {4'h0, service_code};
      default: branch_or = 8'h00;
    endcase
    next_counter = next_step_field | branch_or;
  end

  // load every step; counter addresses the store
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      microstep_counter <= msq_pkg::START_ADDR;
    end else begin
      microstep_counter <= next_counter;
    end
  end

  // ----------------------------------------------------------------------
  // ALU, outputs registered to keep the port timing clean
  // ----------------------------------------------------------------------
  msq_alu #(
    .W(W)
  ) u_alu (
    .fn(alu_fn),
    .bleg_sel(bleg_sel),
    .a(a_bus),
    .b_reg(b_reg),
    .carry_in(carry_in),
    .b_leg(b_leg),
    .result(next_alu_result),
    .shift_in_lsb(next_shift_lsb),
    .shift_in_msb(next_shift_msb)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alu_result <= '0;
      shift_in_lsb <= 1'b0;
      shift_in_msb <= 1'b0;
    end else begin
      alu_result <= next_alu_result;
      shift_in_lsb <= next_shift_lsb;
      shift_in_msb <= next_shift_msb;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_service_idle;
    test_sel == msq_pkg::TEST_SERVICE && !trace_pend && !stack_ovf &&
    !power_fail && bus_req == 4'h0 && !line_clk_pend &&
    !ser_rx_pend && !ser_tx_pend;
  endsequence

  property p_reset_start;
    disable iff (1'b0) !nrst |-> microstep_counter == msq_pkg::START_ADDR;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("counter not at start address in reset");

  property p_plain_step;
    test_sel == msq_pkg::TEST_NONE |=>
      microstep_counter == $past(next_step_field);
  endproperty
  a_plain_step: assert property (p_plain_step)
    else $error("next step field not loaded");

  property p_dest_bits;
    test_sel == msq_pkg::TEST_DEST |=>
      microstep_counter[2:0] == ($past(next_step_field[2:0]) |
                                 $past(instr[5:3])) &&
      microstep_counter[7:3] == $past(next_step_field[7:3]);
  endproperty
  a_dest_bits: assert property (p_dest_bits)
    else $error("destination test touched wrong bits");

  property p_or_code;
    alu_fn == msq_pkg::A_OR_B |=> alu_result == $past(a_bus | b_leg);
  endproperty
  a_or_code: assert property (p_or_code)
    else $error("or code gave wrong result");

  property p_trace_first;
    test_sel == msq_pkg::TEST_SERVICE && trace_pend |=>
      microstep_counter[3:0] == ($past(next_step_field[3:0]) |
                                 msq_pkg::SRV_TRACE);
  endproperty
  a_trace_first: assert property (p_trace_first)
    else $error("trace not highest service priority");

  property p_bus_grant;
    test_sel == msq_pkg::TEST_SERVICE && bus_req[3] && !trace_pend &&
    !stack_ovf && !power_fail |=>
      microstep_counter[3:0] == ($past(next_step_field[3:0]) |
                                 msq_pkg::SRV_BUS_GRANT);
  endproperty
  a_bus_grant: assert property (p_bus_grant)
    else $error("bus request missed common grant entry");

  property p_idle_service;
    s_service_idle |=>
      microstep_counter[3:0] == ($past(next_step_field[3:0]) |
        ($past(wait_active) ? msq_pkg::SRV_WAIT : msq_pkg::SRV_FETCH));
  endproperty
  a_idle_service: assert property (p_idle_service)
    else $error("idle service went to wrong step");

  property p_rotate_in;
    alu_fn == msq_pkg::ROTATE_LEFT |=>
      shift_in_lsb == $past(carry_in) && !shift_in_msb;
  endproperty
  a_rotate_in: assert property (p_rotate_in)
    else $error("rotate left shift-in wrong");

  property p_compare_skip;
    test_sel == msq_pkg::TEST_NONMOD && instr[14:12] == 3'h2 |=>
      microstep_counter[0];
  endproperty
  a_compare_skip: assert property (p_compare_skip)
    else $error("compare did not take skip path");
endmodule : msq_sequencer

// ### msq_sequencer_tb.sv
// Purpose: Self-checking bench for the microstep sequencer and ALU.
// Assumes: Control store model parks each step on its own address.
// Notes:   Carry in is random; it adds to arithmetic codes and feeds rotate shift-ins.
`timescale 1ns/1ps

module msq_sequencer_tb;
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic [47:0] cs_word;
  logic [15:0] instr = 16'h0000, a_bus = 16'h0000, b_reg = 16'h0000;
  logic [3:0] cond_codes = 4'h0, bus_req = 4'h0;
  logic bus_addr_odd = 1'b0, trace_pend = 1'b0, stack_ovf = 1'b0;
  logic power_fail = 1'b0, line_clk_pend = 1'b0, ser_rx_pend = 1'b0;
  logic ser_tx_pend = 1'b0, wait_active = 1'b0, wr_en = 1'b0;
  logic [7:0] wr_addr = 8'h00, cur = 8'h00, microstep_counter;
  logic [47:0] wr_data = 48'h0;
  logic [15:0] alu_result;
  logic shift_in_lsb, shift_in_msb;
  logic [4:0] op_code = 5'h00;
  integer seed = 86788;
  int bad_count = 0, n_checks = 0;
  logic [15:0] op_i [15] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
    16'h0004, 16'h0005, 16'h0007, 16'h0087, 16'h00a1, 16'h0100,
    16'h0300, 16'h1e00, 16'h0a38, 16'h8800, 16'h8900};
  logic [4:0] op_c [15] = '{5'h16, 5'h15, 5'h14, 5'h18, 5'h19, 5'h1c,
    5'h1b, 5'h13, 5'h12, 5'h10, 5'h11, 5'h07, 5'h0f, 5'h17, 5'h1a};

  // ----------------------------------------------------------------
  // Clock and instances
  // ----------------------------------------------------------------
  always #2 clk = ~clk;

  msq_cstore msq_cstore_inst (.clk(clk), .addr(microstep_counter),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .word(cs_word));

  msq_sequencer #(.W(16), .CSW(48)) msq_sequencer_inst (.clk(clk),
    .nrst(nrst), .cs_word(cs_word), .instr(instr),
    .cond_codes(cond_codes), .bus_addr_odd(bus_addr_odd),
    .a_bus(a_bus), .b_reg(b_reg), .trace_pend(trace_pend),
    .stack_ovf(stack_ovf), .power_fail(power_fail), .bus_req(bus_req),
    .line_clk_pend(line_clk_pend), .ser_rx_pend(ser_rx_pend),
    .ser_tx_pend(ser_tx_pend), .wait_active(wait_active),
    .microstep_counter(microstep_counter), .alu_result(alu_result),
    .shift_in_lsb(shift_in_lsb), .shift_in_msb(shift_in_msb));

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  // ALU field at 37:33
  function automatic logic [47:0] mk_word(input logic [4:0] fn,
    input logic [1:0] bs, input logic ci, input logic [2:0] t,
    input logic [7:0] nx);
    return {10'h000, fn, 19'h00000, ci, bs, t, nx};
  endfunction : mk_word

  function automatic logic [3:0] srv_code();
    if (trace_pend) return msq_pkg::SRV_TRACE;
    if (stack_ovf) return msq_pkg::SRV_STACK;
    if (power_fail) return msq_pkg::SRV_PWRF;
    if (bus_req[3] | bus_req[2]) return msq_pkg::SRV_BUS_GRANT;
    if (line_clk_pend) return msq_pkg::SRV_LINE_CLK;
    if (bus_req[1] | bus_req[0]) return msq_pkg::SRV_BUS_GRANT;
    if (ser_rx_pend) return msq_pkg::SRV_SER_RX;
    if (ser_tx_pend) return msq_pkg::SRV_SER_TX;
    return wait_active ? msq_pkg::SRV_WAIT : msq_pkg::SRV_FETCH;
  endfunction : srv_code

  // Branch bits ORed over the next field, per test
  function automatic logic [7:0] exp_next(input logic [47:0] w);
    logic bt;
    logic mv;
    logic nm;
    bt = instr[15] & (((instr[14:12] != 3'h0) & (instr[14:12] < 3'h6)) |
      ((instr[14:6] >= 9'h028) & (instr[14:6] <= 9'h037)));
    mv = instr[14:12] == 3'h1;
    nm = (instr[14:12] == 3'h2) | (instr[14:12] == 3'h3) |
      (instr[14:6] == 9'h02f);
    case (w[10:8])
      msq_pkg::TEST_OPCODE: return w[7:0] | {3'h0, op_code};
      msq_pkg::TEST_DEST: return w[7:0] | {5'h00, instr[5:3]};
      msq_pkg::TEST_DEST_CC: return w[7:0] | {7'h00, instr[4]};
      msq_pkg::TEST_BYTE: return w[7:0] |
        {6'h00, bt & bus_addr_odd & (instr[11:9] != 3'h0), bt};
      msq_pkg::TEST_MOVE: return w[7:0] | {6'h00, mv ?
        (bt ? msq_pkg::MOVE_BYTE : msq_pkg::MOVE_WORD) :
        (bt ? msq_pkg::MOVE_BYTE_OTHER : 2'h0)};
      msq_pkg::TEST_NONMOD: return w[7:0] | {7'h00, nm};
      msq_pkg::TEST_SERVICE: return w[7:0] | {4'h0, srv_code()};
      default: return w[7:0];
    endcase
  endfunction : exp_next

  function automatic logic [15:0] exp_alu(input logic [47:0] w);
    logic [15:0] bl;
    case (w[12:11])
      msq_pkg::SIGN_EXTEND_B: bl = {{8{b_reg[7]}}, b_reg[7:0]};
      msq_pkg::BLEG_ONE: bl = 16'h0001;
      default: bl = b_reg;
    endcase
    case (w[37:33])
      msq_pkg::PASS_A_PLAIN: return a_bus;
      msq_pkg::PASS_A_ARITH: return a_bus + 16'(w[13]);
      msq_pkg::A_AND_B: return a_bus & bl;
      msq_pkg::A_AND_NOT_B: return a_bus & ~bl;
      msq_pkg::ZERO: return 16'h0000;
      msq_pkg::A_PLUS_B: return a_bus + bl + 16'(w[13]);
      msq_pkg::A_EXCLUSIVE_OR_B: return a_bus ^ bl;
      msq_pkg::A_MINUS_B_MINUS_1: return a_bus + ~bl + 16'(w[13]);
      msq_pkg::A_OR_B: return a_bus | bl;
      msq_pkg::INVERT_B: return ~bl;
      msq_pkg::ALL_ONES: return 16'hffff;
      msq_pkg::A_MINUS_1: return a_bus - 16'h0001 + 16'(w[13]);
      msq_pkg::INVERT_A: return ~a_bus;
      default: return bl;
    endcase
  endfunction : exp_alu

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Load one word at the parked step, run it, then re-park the slot
  task automatic do_step(input logic [47:0] w);
    logic [7:0] old;
    logic [4:0] fn;
    old = cur;
    fn = w[37:33];
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= old;
    wr_data <= w;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
    #1;
    check("counter", {8'h00, microstep_counter},
      {8'h00, exp_next(w)});
    check("alu_result", alu_result, exp_alu(w));
    check("shift_in_lsb", {15'h0, shift_in_lsb},
      {15'h0, fn == msq_pkg::ROTATE_LEFT && w[13]});
    check("shift_in_msb", {15'h0, shift_in_msb}, {15'h0,
      (fn == msq_pkg::ARITH_SHIFT_RIGHT) ? b_reg[15] :
      (fn == msq_pkg::ROTATE_RIGHT && w[13])});
    cur = exp_next(w);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= old;
    wr_data <= mk_word(5'h00, 2'h0, 1'b0, 3'h0, old);
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : do_step

  task automatic reset_check();
    #1;
    check("reset counter", {8'h00, microstep_counter},
      {8'h00, msq_pkg::START_ADDR});
    check("reset alu", alu_result, 16'h0000);
    cur = msq_pkg::START_ADDR;
  endtask : reset_check

  // Random step: any test, any ALU code, random inputs
  task automatic rnd_step();
    logic [2:0] t;
    logic [4:0] fn;
    logic [7:0] nx;
    logic [15:0] r;
    int k;
    t = 3'($random(seed));
    k = {$random(seed)} % 18;
    fn = (k < 14) ? 5'(k) : 5'(k + 2);
    nx = 8'($random(seed));
    r = 16'($random(seed));
    if (t != msq_pkg::TEST_NONE) nx = nx & 8'he0;
    k = {$random(seed)} % 15;
    op_code = op_c[k];
    if (t == msq_pkg::TEST_OPCODE) begin
      instr <= op_i[k];
      cond_codes <= 4'h0;
    end else begin
      instr <= r[7] ? {r[15], 3'(1 + {$random(seed)} % 6), r[11:0]} :
        {r[15], 9'h02f, r[5:0]};
      cond_codes <= 4'($random(seed));
    end
    a_bus <= 16'($random(seed));
    b_reg <= 16'($random(seed));
    bus_addr_odd <= 1'($random(seed));
    wait_active <= 1'($random(seed));
    trace_pend <= ({$random(seed)} % 4) == 0;
    stack_ovf <= ({$random(seed)} % 4) == 0;
    power_fail <= ({$random(seed)} % 4) == 0;
    line_clk_pend <= ({$random(seed)} % 3) == 0;
    ser_rx_pend <= ({$random(seed)} % 2) == 0;
    ser_tx_pend <= ({$random(seed)} % 2) == 0;
    bus_req <= 4'($random(seed)) & 4'($random(seed));
    do_step(mk_word(fn, 2'($random(seed)), 1'($random(seed)),
      t, nx));
  endtask : rnd_step

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    // Falling edge at time zero, after the initial high, so the async reset really fires
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    reset_check();
    @(posedge clk);
    nrst <= 1'b1;
    a_bus <= 16'h00f0;
    b_reg <= 16'h0f00;
    do_step(mk_word(msq_pkg::A_OR_B, msq_pkg::BLEG_B, 1'b0,
      msq_pkg::TEST_NONE, 8'h25));
    for (int k = 0; k < 15; k++) begin
      instr <= op_i[k];
      op_code = op_c[k];
      do_step(mk_word(5'h00, 2'h0, 1'b0, msq_pkg::TEST_OPCODE, 8'h40));
    end
    for (int i = 0; i < 320; i++) begin
      rnd_step();
      if (i == 160) begin
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        reset_check();
        @(posedge clk);
        nrst <= 1'b1;
      end
    end
    report_and_stop();
  end

  // Hang guard, well past the expected 1704 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : msq_sequencer_tb
